// *** design/twc_regs.svh ***
`ifndef TWC_REGS_SVH
`define TWC_REGS_SVH

// ****************************************
// timing
// ****************************************
`define TWC_CLK_PERIOD_NS 10
`define TWC_SPIKE_NS 50
`define TWC_SPIKE_CYC ((`TWC_SPIKE_NS + `TWC_CLK_PERIOD_NS - 1) / `TWC_CLK_PERIOD_NS)
`define TWC_PERIOD_BASE 16
`define TWC_HALF_BASE (`TWC_PERIOD_BASE / 2)

// ****************************************
// fields and reset values
// ****************************************
`define TWC_GC_ADDR 7'h00
`define TWC_BIT_ADDR_END 4'h7
`define TWC_BIT_ACK 4'h8
`define TWC_CTRL_RST 5'h00
`define TWC_SHIFT_RST 8'hFF

`endif

// *** design/twc_pkg.sv ***
package twc_pkg;

   typedef struct packed {
      logic int_clear;
      logic enable;
      logic start;
      logic stop;
      logic ack_en;
   } twc_ctrl_t;

   // status codes, values arbitrary
   typedef enum logic [7:0] {
      SC_NO_INFO = 8'hFF,
      SC_START_SENT = 8'h01,
      SC_RSTART_SENT = 8'h02,
      SC_ADDR_ACK = 8'h03,
      SC_ADDR_NACK = 8'h04,
      SC_DTX_ACK = 8'h05,
      SC_DTX_NACK = 8'h06,
      SC_DRX_ACK = 8'h07,
      SC_DRX_NACK = 8'h08,
      SC_ARB_LOST = 8'h09,
      SC_ARB_LOST_ADDR = 8'h0A,
      SC_SLV_WRITE = 8'h0B,
      SC_SLV_GCALL = 8'h0C,
      SC_SLV_READ = 8'h0D,
      SC_SLV_RX_ACK = 8'h0E,
      SC_SLV_RX_NACK = 8'h0F,
      SC_SLV_STOP = 8'h10,
      SC_SLV_TX_ACK = 8'h11,
      SC_SLV_TX_NACK = 8'h12,
      SC_BUS_ERR = 8'h1F
   } twc_status_t;

   typedef enum logic [6:0] {
      ST_IDLE = 7'b0000001,
      ST_START = 7'b0000010,
      ST_MLOW = 7'b0000100,
      ST_MHIGH = 7'b0001000,
      ST_STOP = 7'b0010000,
      ST_SLAVE = 7'b0100000,
      ST_HOLD = 7'b1000000
   } twc_state_t;

endpackage : twc_pkg

// *** design/twc_spike_filter.sv ***
`timescale 1ns/100ps
`include "twc_regs.svh"

module twc_spike_filter (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic line_i,
   output logic line_f
);
   import twc_pkg::*;

   logic [2:0] cnt_r;

   // output follows only after the input differs for the full width
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         cnt_r <= 3'h0;
         line_f <= 1'b1;
      end
      else if (line_i == line_f)
         cnt_r <= 3'h0;
      else if (cnt_r == 3'(`TWC_SPIKE_CYC - 1))
      begin
         cnt_r <= 3'h0;
         line_f <= line_i;
      end
      else
         cnt_r <= cnt_r + 3'h1;
   end

endmodule : twc_spike_filter

// *** design/twc_rate_gen.sv ***
`timescale 1ns/100ps
`include "twc_regs.svh"

module twc_rate_gen (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [7:0] bit_rate_divider,
   input wire logic [1:0] rate_prescaler_select,
   input wire logic restart,
   input wire logic run,
   input wire logic high_phase,
   output logic tick
);
   import twc_pkg::*;

   logic [14:0] cnt_r;
   wire [14:0] half_len;
   wire [14:0] lim;

   assign half_len = 15'(`TWC_HALF_BASE)
      + ({7'h00, bit_rate_divider} << {rate_prescaler_select, 1'b0});
   // high phase starts late by the input filter delay
   assign lim = high_phase ? (half_len - 15'(`TWC_SPIKE_CYC)) : half_len;
   assign tick = run & (cnt_r == (lim - 15'h0001));

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         cnt_r <= 15'h0000;
      else if (restart | tick | ~run)
         cnt_r <= 15'h0000;
      else
         cnt_r <= cnt_r + 15'h0001;
   end

endmodule : twc_rate_gen

// *** design/twc_controller.sv ***
`timescale 1ns/100ps
`include "twc_regs.svh"

module twc_controller (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic scl_i,
   output logic scl_o,
   output logic scl_oe,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   input wire logic ctrl_wr,
   input wire twc_pkg::twc_ctrl_t ctrl_in,
   output twc_pkg::twc_ctrl_t control_reg,
   input wire logic data_wr,
   input wire logic [7:0] data_in,
   output logic [7:0] shift_data_reg,
   input wire logic [6:0] own_address_reg,
   input wire logic general_call_enable,
   input wire logic [7:0] bit_rate_divider,
   input wire logic [1:0] rate_prescaler_select,
   input wire logic cpu_sleep,
   input wire logic other_wake,
   output logic event_flag,
   output twc_pkg::twc_status_t status_code_reg,
   output logic wake_req
);
   import twc_pkg::*;

   twc_state_t state_r, state_nxt;
   twc_status_t pend_r, evt_code;
   twc_ctrl_t ctrl_r;
   logic [1:0] ph_r, ph_nxt;
   logic [3:0] bitcnt_r, bit_nxt;
   logic [7:0] shift_r, shift_nxt;
   logic ack_bit_r, ackb_nxt, s_bit_r, sbit_nxt;
   logic master_r, master_nxt, rd_r, rd_nxt, addr_ph_r, addr_nxt;
   logic arb_r, arb_nxt, addressed_r, adr_nxt, slv_tx_r, stx_nxt, gcall_r, gc_nxt;
   logic scl_drv_r, scl_nxt, sda_drv_r, sda_nxt, scl_d_r, sda_d_r;
   logic flag_r, busy_r, wake_r, wake_nxt;
   logic evt, step, start_done, stop_done;
   wire [1:0] lines_raw;
   wire [1:0] lines_f;
   wire scl_f, sda_f, tick, hi_ph, run;

   // ****************************************
   // input filtering and line events
   // ****************************************
   assign lines_raw = {scl_i, sda_i};
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi = gi + 1)
      begin : g_filt
         twc_spike_filter u_filt (
            .clk(clk),
            .sys_rst(sys_rst),
            .line_i(lines_raw[gi]),
            .line_f(lines_f[gi])
         );
      end
   endgenerate
   assign scl_f = lines_f[1];
   assign sda_f = lines_f[0];

   wire scl_rise = scl_f & ~scl_d_r;
   wire scl_fall = ~scl_f & scl_d_r;
   wire scl_hi2 = scl_f & scl_d_r;
   wire start_det = scl_hi2 & sda_d_r & ~sda_f;
   wire stop_det = scl_hi2 & ~sda_d_r & sda_f;
   wire cond_det = start_det | stop_det;
   wire flag_clr = ctrl_wr & ctrl_in.int_clear;
   wire at_ack = (bitcnt_r == `TWC_BIT_ACK);

   // ****************************************
   // bit rate
   // ****************************************
   assign hi_ph = (state_r == ST_MHIGH)
      | ((ph_r == 2'd1) & ((state_r == ST_START) | (state_r == ST_STOP)));
   assign run = scl_drv_r | scl_f;

   twc_rate_gen u_rate (
      .clk(clk),
      .sys_rst(sys_rst),
      .bit_rate_divider(bit_rate_divider),
      .rate_prescaler_select(rate_prescaler_select),
      .restart(step),
      .run(run),
      .high_phase(hi_ph),
      .tick(tick)
   );

   // ****************************************
   // bit level decode
   // ****************************************
   wire m_tx = addr_ph_r | ~rd_r;
   wire m_bit = at_ack ? (m_tx | ~ack_bit_r) : (~m_tx | shift_r[7]);
   wire m_lost = master_r & m_tx & ~at_ack & m_bit & ~sda_f;
   wire hi_end = tick | scl_fall;
   wire [7:0] byte_in = {shift_r[6:0], s_bit_r};
   wire gc_hit = general_call_enable & (byte_in[7:1] == `TWC_GC_ADDR);
   wire own_hit = (byte_in[7:1] == own_address_reg);
   wire match = own_hit | gc_hit;
   wire s_drive = at_ack ? (~slv_tx_r & ack_bit_r) : (slv_tx_r & ~shift_r[7]);

   // ****************************************
   // control state machine
   // ****************************************
   always_comb
   begin
      state_nxt = state_r;
      ph_nxt = ph_r;
      bit_nxt = bitcnt_r;
      shift_nxt = (data_wr & flag_r) ? data_in : shift_r;
      ackb_nxt = ack_bit_r;
      sbit_nxt = s_bit_r;
      master_nxt = master_r;
      rd_nxt = rd_r;
      addr_nxt = addr_ph_r;
      arb_nxt = arb_r;
      adr_nxt = addressed_r;
      stx_nxt = slv_tx_r;
      gc_nxt = gcall_r;
      scl_nxt = scl_drv_r;
      sda_nxt = sda_drv_r;
      evt = 1'b0;
      evt_code = SC_NO_INFO;
      step = 1'b0;
      start_done = 1'b0;
      stop_done = 1'b0;
      wake_nxt = 1'b0;
      case (state_r)
         ST_IDLE:
         begin
            scl_nxt = 1'b0;
            sda_nxt = 1'b0;
            master_nxt = 1'b0;
            arb_nxt = 1'b0;
            adr_nxt = 1'b0;
            stx_nxt = 1'b0;
            if (!flag_r && ctrl_r.start && !busy_r)
            begin
               state_nxt = ST_START;
               ph_nxt = 2'd1;
               step = 1'b1;
            end
            else if (start_det)
            begin
               state_nxt = ST_SLAVE;
               bit_nxt = 4'h0;
               addr_nxt = 1'b1;
               ackb_nxt = 1'b0;
            end
         end
         ST_START:
         begin
            if (ph_r == 2'd0)
            begin
               sda_nxt = 1'b0;
               if (tick)
               begin
                  ph_nxt = 2'd1;
                  scl_nxt = 1'b0;
                  step = 1'b1;
               end
            end
            else if (ph_r == 2'd1)
            begin
               if (tick && scl_f && sda_f)
               begin
                  ph_nxt = 2'd2;
                  sda_nxt = 1'b1;
                  step = 1'b1;
               end
            end
            else if (tick)
            begin
               scl_nxt = 1'b1;
               evt = 1'b1;
               evt_code = master_r ? SC_RSTART_SENT : SC_START_SENT;
               master_nxt = 1'b1;
               addr_nxt = 1'b1;
               rd_nxt = 1'b0;
               arb_nxt = 1'b0;
               bit_nxt = 4'h0;
               start_done = 1'b1;
               state_nxt = ST_HOLD;
            end
         end
         ST_HOLD:
         begin
            scl_nxt = 1'b1;
            if (!flag_r)
            begin
               step = 1'b1;
               if (master_r && ctrl_r.stop)
               begin
                  state_nxt = ST_STOP;
                  ph_nxt = 2'd0;
               end
               else if (master_r && ctrl_r.start)
               begin
                  state_nxt = ST_START;
                  ph_nxt = 2'd0;
               end
               else if (master_r)
               begin
                  state_nxt = ST_MLOW;
                  ackb_nxt = ctrl_r.ack_en;
               end
               else if (addressed_r || addr_ph_r)
               begin
                  state_nxt = ST_SLAVE;
                  scl_nxt = 1'b0;
               end
               else
                  state_nxt = ST_IDLE;
            end
         end
         ST_MLOW:
         begin
            scl_nxt = 1'b1;
            sda_nxt = ~m_bit;
            if (cond_det)
            begin
               evt = 1'b1;
               evt_code = SC_BUS_ERR;
               master_nxt = 1'b0;
               sda_nxt = 1'b0;
               state_nxt = ST_HOLD;
            end
            else if (tick)
            begin
               scl_nxt = 1'b0;
               state_nxt = ST_MHIGH;
               step = 1'b1;
            end
         end
         ST_MHIGH:
         begin
            scl_nxt = 1'b0;
            if (cond_det)
            begin
               evt = 1'b1;
               evt_code = SC_BUS_ERR;
               master_nxt = 1'b0;
               sda_nxt = 1'b0;
               scl_nxt = 1'b1;
               state_nxt = ST_HOLD;
            end
            else if (hi_end && scl_f)
            begin
               if (!at_ack)
                  shift_nxt = {shift_r[6:0], sda_f};
               if (m_lost)
               begin
                  arb_nxt = 1'b1;
                  shift_nxt = shift_r;
                  sbit_nxt = sda_f;
                  master_nxt = 1'b0;
                  sda_nxt = 1'b0;
                  ackb_nxt = 1'b0;
                  state_nxt = ST_SLAVE;
               end
               else if (at_ack)
               begin
                  evt = 1'b1;
                  if (m_tx)
                     ackb_nxt = ~sda_f;
                  if (addr_ph_r)
                  begin
                     rd_nxt = shift_r[0];
                     evt_code = sda_f ? SC_ADDR_NACK : SC_ADDR_ACK;
                  end
                  else if (m_tx)
                     evt_code = sda_f ? SC_DTX_NACK : SC_DTX_ACK;
                  else
                     evt_code = ack_bit_r ? SC_DRX_ACK : SC_DRX_NACK;
                  addr_nxt = 1'b0;
                  bit_nxt = 4'h0;
                  scl_nxt = 1'b1;
                  state_nxt = ST_HOLD;
               end
               else
               begin
                  bit_nxt = bitcnt_r + 4'h1;
                  scl_nxt = 1'b1;
                  state_nxt = ST_MLOW;
                  step = 1'b1;
               end
            end
         end
         ST_STOP:
         begin
            if (ph_r == 2'd0)
            begin
               scl_nxt = 1'b1;
               sda_nxt = 1'b1;
               if (tick)
               begin
                  ph_nxt = 2'd1;
                  scl_nxt = 1'b0;
                  step = 1'b1;
               end
            end
            else if (ph_r == 2'd1)
            begin
               if (tick && scl_f)
               begin
                  ph_nxt = 2'd2;
                  sda_nxt = 1'b0;
                  step = 1'b1;
               end
            end
            else if (tick)
            begin
               master_nxt = 1'b0;
               stop_done = 1'b1;
               state_nxt = ST_IDLE;
            end
         end
         ST_SLAVE:
         begin
            scl_nxt = 1'b0;
            sda_nxt = s_drive;
            if (cpu_sleep && other_wake)
            begin
               adr_nxt = 1'b0;
               addr_nxt = 1'b0;
               sda_nxt = 1'b0;
               state_nxt = ST_IDLE;
            end
            else if (cond_det)
            begin
               bit_nxt = 4'h0;
               addr_nxt = start_det;
               adr_nxt = 1'b0;
               stx_nxt = 1'b0;
               ackb_nxt = 1'b0;
               sda_nxt = 1'b0;
               if (bitcnt_r != 4'h0)
               begin
                  evt = 1'b1;
                  evt_code = SC_BUS_ERR;
                  addr_nxt = 1'b0;
                  state_nxt = ST_HOLD;
               end
               else if (addressed_r)
               begin
                  evt = 1'b1;
                  evt_code = SC_SLV_STOP;
                  state_nxt = ST_HOLD;
               end
               else if (stop_det)
                  state_nxt = ST_IDLE;
            end
            else if (scl_rise)
               sbit_nxt = sda_f;
            else if (scl_fall && !at_ack)
            begin
               shift_nxt = byte_in;
               bit_nxt = bitcnt_r + 4'h1;
               if (bitcnt_r == `TWC_BIT_ADDR_END)
               begin
                  if (addr_ph_r)
                  begin
                     adr_nxt = match & ctrl_r.ack_en;
                     ackb_nxt = match & ctrl_r.ack_en;
                     gc_nxt = gc_hit;
                     stx_nxt = match & ~gc_hit & byte_in[0];
                     wake_nxt = match & ctrl_r.ack_en & cpu_sleep;
                  end
                  else
                     ackb_nxt = addressed_r & ~slv_tx_r & ctrl_r.ack_en;
               end
            end
            else if (scl_fall)
            begin
               bit_nxt = 4'h0;
               addr_nxt = 1'b0;
               if (slv_tx_r)
                  ackb_nxt = ~s_bit_r;
               if (addressed_r)
               begin
                  evt = 1'b1;
                  scl_nxt = 1'b1;
                  state_nxt = ST_HOLD;
                  if (addr_ph_r)
                     evt_code = arb_r ? SC_ARB_LOST_ADDR
                        : (gcall_r ? SC_SLV_GCALL : (slv_tx_r ? SC_SLV_READ : SC_SLV_WRITE));
                  else if (slv_tx_r)
                     evt_code = s_bit_r ? SC_SLV_TX_NACK : SC_SLV_TX_ACK;
                  else
                     evt_code = ack_bit_r ? SC_SLV_RX_ACK : SC_SLV_RX_NACK;
                  if (!addr_ph_r && (slv_tx_r ? s_bit_r : ~ack_bit_r))
                     adr_nxt = 1'b0;
                  arb_nxt = 1'b0;
               end
               else if (arb_r)
               begin
                  evt = 1'b1;
                  evt_code = SC_ARB_LOST;
                  arb_nxt = 1'b0;
                  scl_nxt = 1'b1;
                  state_nxt = ST_HOLD;
               end
               else
                  state_nxt = ST_IDLE;
            end
         end
         default:
            state_nxt = ST_IDLE;
      endcase
      if (!ctrl_r.enable)
      begin
         state_nxt = ST_IDLE;
         scl_nxt = 1'b0;
         sda_nxt = 1'b0;
         master_nxt = 1'b0;
         adr_nxt = 1'b0;
         addr_nxt = 1'b0;
         evt = 1'b0;
      end
   end

   // ****************************************
   // registers
   // ****************************************
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         state_r <= ST_IDLE;
         ph_r <= 2'd0;
         bitcnt_r <= 4'h0;
         shift_r <= `TWC_SHIFT_RST;
         {ack_bit_r, s_bit_r, master_r, rd_r, addr_ph_r} <= 5'h00;
         {arb_r, addressed_r, slv_tx_r, gcall_r, wake_r} <= 5'h00;
         {scl_drv_r, sda_drv_r} <= 2'b00;
      end
      else
      begin
         state_r <= state_nxt;
         ph_r <= ph_nxt;
         bitcnt_r <= bit_nxt;
         shift_r <= shift_nxt;
         {ack_bit_r, s_bit_r, master_r, rd_r, addr_ph_r} <=
            {ackb_nxt, sbit_nxt, master_nxt, rd_nxt, addr_nxt};
         {arb_r, addressed_r, slv_tx_r, gcall_r, wake_r} <=
            {arb_nxt, adr_nxt, stx_nxt, gc_nxt, wake_nxt};
         {scl_drv_r, sda_drv_r} <= {scl_nxt, sda_nxt};
      end
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         scl_d_r <= 1'b1;
         sda_d_r <= 1'b1;
         busy_r <= 1'b0;
      end
      else
      begin
         scl_d_r <= scl_f;
         sda_d_r <= sda_f;
         busy_r <= start_det | (busy_r & ~stop_det);
      end
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         ctrl_r <= `TWC_CTRL_RST;
      else if (ctrl_wr)
         ctrl_r <= {1'b0, ctrl_in.enable, ctrl_in.start, ctrl_in.stop, ctrl_in.ack_en};
      else
      begin
         ctrl_r.start <= ctrl_r.start & ~start_done;
         ctrl_r.stop <= ctrl_r.stop & ~stop_done;
      end
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         flag_r <= 1'b0;
         pend_r <= SC_NO_INFO;
         status_code_reg <= SC_NO_INFO;
      end
      else
      begin
         flag_r <= evt | (flag_r & ~flag_clr);
         if (evt)
            pend_r <= evt_code;
         status_code_reg <= flag_r ? pend_r : SC_NO_INFO;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   assign scl_o = 1'b0;
   assign sda_o = 1'b0;
   assign scl_oe = scl_drv_r;
   assign sda_oe = sda_drv_r;
   assign control_reg = ctrl_r;
   assign shift_data_reg = shift_r;
   assign event_flag = flag_r;
   assign wake_req = wake_r;

endmodule : twc_controller

// *** tb/twc_controller_sva.sv ***
`timescale 1ns/100ps
// **********
// port checks
// **********
module twc_controller_sva (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic scl_o,
   input wire logic scl_oe,
   input wire logic sda_o,
   input wire logic sda_oe,
   input wire logic ctrl_wr,
   input wire twc_pkg::twc_ctrl_t ctrl_in,
   input wire twc_pkg::twc_ctrl_t control_reg,
   input wire logic event_flag,
   input wire twc_pkg::twc_status_t status_code_reg
);
   import twc_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   chk_code_after_flag: assert property ($rose(event_flag) |=> status_code_reg != SC_NO_INFO)
      else $error("status code not loaded");
   chk_no_info: assert property (!event_flag && !$past(event_flag) |-> status_code_reg == SC_NO_INFO)
      else $error("status code without flag");
   chk_info_return: assert property ($fell(event_flag) |=> status_code_reg == SC_NO_INFO)
      else $error("status code not returned");
   chk_scl_stall: assert property (event_flag && $past(event_flag) |-> scl_oe)
      else $error("scl released while flag set");
   chk_open_drain: assert property (!scl_o && !sda_o)
      else $error("pin drives high");
   chk_sda_frozen: assert property (event_flag && $past(event_flag) |-> $stable(sda_oe))
      else $error("sda moved while flag set");
   chk_ctrl_taken: assert property (ctrl_wr |=> control_reg.enable == $past(ctrl_in.enable)
      && !control_reg.int_clear) else $error("control write lost");
   chk_flag_stays: assert property (event_flag && !(ctrl_wr && ctrl_in.int_clear) |=> event_flag)
      else $error("flag dropped by itself");
   cover property ($rose(event_flag));
   cover property (status_code_reg == SC_ADDR_ACK);
   cover property (status_code_reg == SC_ARB_LOST);
endmodule : twc_controller_sva

bind twc_controller twc_controller_sva u_sva (.clk, .sys_rst, .scl_o, .scl_oe, .sda_o, .sda_oe,
   .ctrl_wr, .ctrl_in, .control_reg, .event_flag, .status_code_reg);

// *** tb/twc_bus_model.sv ***
`timescale 1ns/100ps
// **********
// slave on the bus, clocked by scl edges, reset when sda falls while scl is high
// **********
module twc_bus_model #(parameter logic [6:0] ADDR = 7'h2A) (
   input wire logic scl,
   input wire logic sda,
   output logic sda_oe
);
   logic [7:0] sh;
   logic sel;
   int n;
   initial
   begin
      sda_oe = 1'h0;
      sel = 1'h0;
      n = 0;
   end
   always @(negedge sda)
      if (scl)
      begin
         n = 0;
         sel = 1'h0;
      end
   always @(posedge scl)
   begin
      sh = {sh[6:0], sda};
      n = n + 1;
   end
   always @(negedge scl)
   begin
      sda_oe <= 1'h0;
      if (n == 8 && (sel || sh[7:1] == ADDR))
      begin
         sda_oe <= 1'h1;
         sel <= 1'h1;
      end
      if (n == 9)
         n = 0;
   end
endmodule : twc_bus_model

// *** tb/test_two_wire_multimaster_controller.sv ***
`timescale 1ns/100ps
module test_two_wire_multimaster_controller;
   import twc_pkg::*;
   localparam logic [7:0] DIV = 8'h03;
   localparam logic [1:0] PS = 2'h1;
   logic clk, sys_rst, ctrl_wr, data_wr, tb_scl_oe, tb_sda_oe, scl_d;
   logic scl_oe, sda_oe, m_sda_oe, event_flag;
   twc_ctrl_t ctrl_in, control_reg;
   twc_status_t status_code_reg;
   logic [7:0] data_in, shift_data_reg;
   int n_errors, checks, cyc, per;
   wire scl = ~(scl_oe | tb_scl_oe);
   wire sda = ~(sda_oe | m_sda_oe | tb_sda_oe);
   twc_controller uut (.clk(clk), .sys_rst(sys_rst), .scl_i(scl), .scl_o(), .scl_oe(scl_oe),
      .sda_i(sda), .sda_o(), .sda_oe(sda_oe), .ctrl_wr(ctrl_wr), .ctrl_in(ctrl_in),
      .control_reg(control_reg), .data_wr(data_wr), .data_in(data_in),
      .shift_data_reg(shift_data_reg), .own_address_reg(7'h11), .general_call_enable(1'h0),
      .bit_rate_divider(DIV), .rate_prescaler_select(PS), .cpu_sleep(1'h0),
      .other_wake(1'h0), .event_flag(event_flag), .status_code_reg(status_code_reg),
      .wake_req());
   twc_bus_model slv (.scl(scl), .sda(sda), .sda_oe(m_sda_oe));
   initial
   begin
      clk = 1'h0;
      forever #5 clk = ~clk;
   end
   // **********
   // scl period between falls
   // **********
   always @(posedge clk)
   begin
      scl_d <= scl;
      cyc <= cyc + 1;
      if (scl_d && !scl)
      begin
         per <= cyc;
         cyc <= 1;
      end
   end
   task final_report;
      $display("checks %0d errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : final_report
   task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks++;
      if (got !== exp)
      begin
         $display("[ERR] %s expected %h seen %h", what, exp, got);
         n_errors++;
      end
   endtask : chk
   task wr_ctrl(input logic [4:0] c);
      @(posedge clk);
      ctrl_wr <= 1'h1;
      ctrl_in <= c;
      @(posedge clk);
      ctrl_wr <= 1'h0;
      #1;
   endtask : wr_ctrl
   task send(input logic [7:0] d);
      @(posedge clk);
      data_wr <= 1'h1;
      data_in <= d;
      @(posedge clk);
      data_wr <= 1'h0;
      wr_ctrl(5'h19);
      chk("event_flag", 8'h00, {7'h00, event_flag});
   endtask : send
   task wait_flag(input logic [7:0] code);
      int i;
      for (i = 0; i < 4000 && event_flag !== 1'h1; i++)
      begin
         @(posedge clk);
         #1;
      end
      if (i == 4000)
      begin
         $display("[ERR] event_flag expected 1 seen %b", event_flag);
         n_errors++;
         final_report;
      end
      @(posedge clk);
      #1;
      chk("status_code_reg", code, status_code_reg);
      chk("scl", 8'h00, {7'h00, scl});
   endtask : wait_flag
   // **********
   // main sequence
   // **********
   initial
   begin
      {sys_rst, ctrl_wr, data_wr, tb_scl_oe, tb_sda_oe} = 5'h10;
      ctrl_in = '0;
      data_in = 8'h00;
      {n_errors, checks, cyc, per} = '0;
      repeat (3) @(posedge clk);
      sys_rst <= 1'h0;
      #1;
      chk("status_code_reg", SC_NO_INFO, status_code_reg);
      chk("shift_data_reg", 8'hFF, shift_data_reg);
      wr_ctrl(5'h1C);
      wait_flag(SC_START_SENT);
      send({7'h2A, 1'h0});
      wait_flag(SC_ADDR_ACK);
      send(8'hA5);
      wait_flag(SC_DTX_ACK);
      chk("scl period", 8'(16 + 2 * DIV * (4 ** PS)), per[7:0]);
      wr_ctrl(5'h1C);
      wait_flag(SC_RSTART_SENT);
      send({7'h15, 1'h0});
      wait_flag(SC_ADDR_NACK);
      wr_ctrl(5'h1A);
      repeat (200) @(posedge clk);
      #1;
      chk("event_flag", 8'h00, {7'h00, event_flag});
      chk("scl sda", 8'h03, {6'h00, scl, sda});
      wr_ctrl(5'h1C);
      wait_flag(SC_START_SENT);
      // other master sends address zero while we send a one
      send(8'h80);
      tb_sda_oe <= 1'h1;
      repeat (80) @(posedge clk);
      repeat (8)
      begin
         tb_scl_oe <= 1'h1;
         repeat (20) @(posedge clk);
         tb_scl_oe <= 1'h0;
         repeat (20) @(posedge clk);
         chk("sda_oe", 8'h00, {7'h00, sda_oe});
      end
      tb_scl_oe <= 1'h1;
      wait_flag(SC_ARB_LOST);
      tb_sda_oe <= 1'h0;
      final_report;
   end
endmodule : test_two_wire_multimaster_controller
